// File: src/voer_pkg.sv
// voer_pkg: constants, states and carriers of the video output id/enable regs
// assumes: 8-bit subaddressed registers behind a two-wire serial port
package voer_pkg;

   // subaddresses
   localparam logic [7:0] ADDR_MAKER_ID    = 8'h00;
   localparam logic [7:0] ADDR_PART_LOW    = 8'h01;
   localparam logic [7:0] ADDR_PART_HIGH   = 8'h02;
   localparam logic [7:0] ADDR_FIELD_STAT  = 8'h03;
   localparam logic [7:0] ADDR_OUT_ENABLE  = 8'hf2;
   localparam logic [7:0] ADDR_STRENGTH_A  = 8'hf8;
   localparam logic [7:0] ADDR_STRENGTH_B  = 8'hf9;

   // reset values of the writable registers, and the value read at unmapped subaddresses
   localparam logic [7:0] RST_OUT_ENABLE   = 8'h00;
   localparam logic [7:0] RST_STRENGTH_A   = 8'h00;
   localparam logic [7:0] RST_STRENGTH_B   = 8'h00;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // output enable bits
   localparam int OE_PORT_A     = 0;
   localparam int OE_PORT_B     = 1;
   localparam int OE_PIXEL_CLK  = 2;
   localparam int OE_SYNC_GROUP = 3;
   localparam int OE_HALF_LINE  = 4;

   // strength field positions
   localparam int STR_LO_LSB   = 0;
   localparam int STR_MID_LSB  = 3;
   localparam int STR_TOP_LSB  = 6;

   // serial framing
   localparam logic [3:0] BITS_DATA = 4'h8;
   localparam logic [3:0] BITS_ACK  = 4'h9;

   typedef enum logic [2:0] {
      VOER_IDLE  = 3'b000,
      VOER_ADDR  = 3'b001,
      VOER_SUB   = 3'b010,
      VOER_WDATA = 3'b011,
      VOER_RDATA = 3'b100
   } voer_state_e;

   typedef struct packed {
      logic [2:0] port_a_data_strength;
      logic [2:0] clock_group_strength;
      logic [2:0] pixel_clock_strength;
      logic [2:0] port_b_data_strength;
      logic [2:0] sync_group_strength;
   } voer_strength_s;

   typedef struct packed {
      logic port_a_oe;
      logic port_b_oe;
      logic pixel_clock_oe;
      logic sync_group_oe;
      logic test_data_out;
      logic test_data_out_oe;
   } voer_enable_s;

endpackage

// File: src/voer_regs.sv
// voer_regs: id, status, pad strength and output enable registers
// assumes: host reaches them over the serial port (scl/sda pins, sampled);
// field indicator, half-rate clock and tap state come from same-clock logic
//
// Operation
// - subaddress 00 reads back the eight-bit maker identification code.
// - part number: low byte at subaddress 01, high byte at 02.
// - subaddress 03 bit 0 is field indicator; host ignores bits 7:1.
// - strength A bits 2:0 drive port A; bits 5:3 clock group.
// - pixel clock strength is bits 5:3 ORed with bits 7:6 shifted left.
// - strength B bits 2:0 drive port B; bits 5:3 sync group.
// - enable bit 0 drives port A, else high impedance.
// - enable bit 1 drives port B, else high impedance.
// - enable bit 2 drives pixel clock output, else high impedance.
// - enable bit 3 drives syncs, references and line clocks, else tri-state.
// - enable bit 4 routes half-rate clock to test pin in reset state.
`timescale 1ns/1ns
module voer_regs #(
   parameter logic [6:0]  DEVICE_ADDR = 7'h43,  // arbitrary
   parameter logic [7:0]  MAKER_ID    = 8'h5a,  // arbitrary
   parameter logic [15:0] PART_NUMBER = 16'h1234 // arbitrary
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output      logic                    sda_out,
   output      logic                    sda_oe,
   input  wire logic                    field_indicator,
   input  wire logic                    half_rate_line_clock,
   input  wire logic                    tap_test_logic_reset,
   output      voer_pkg::voer_strength_s strength,
   output      voer_pkg::voer_enable_s   enables
);

   typedef struct packed {
      logic [1:0]            scl_sync;
      logic [1:0]            sda_sync;
      logic                  scl_prev;
      logic                  sda_prev;
      voer_pkg::voer_state_e st;
      logic [3:0]            bitcnt;
      logic [7:0]            shreg;
      logic [7:0]            sub;
      logic                  pull_low;
      logic [7:0]            out_enable;
      logic [7:0]            strength_a;
      logic [7:0]            strength_b;
      voer_pkg::voer_strength_s strength;
      voer_pkg::voer_enable_s   enables;
   } voer_regs_s;

   voer_regs_s r;
   voer_regs_s next_r;

   ////////////////////////////////////////////////////////////////////////
   // read mux

   function automatic logic [7:0] read_reg(input logic [7:0] a,
                                           input voer_regs_s  s,
                                           input logic        fld);
      logic [7:0] v;
      v = voer_pkg::READ_UNMAPPED;
      case (a)
         voer_pkg::ADDR_MAKER_ID:   v = MAKER_ID;
         voer_pkg::ADDR_PART_LOW:   v = PART_NUMBER[7:0];
         voer_pkg::ADDR_PART_HIGH:  v = PART_NUMBER[15:8];
         voer_pkg::ADDR_FIELD_STAT: v = {7'h00, fld};
         voer_pkg::ADDR_OUT_ENABLE: v = s.out_enable;
         voer_pkg::ADDR_STRENGTH_A: v = s.strength_a;
         voer_pkg::ADDR_STRENGTH_B: v = s.strength_b;
         default:                   v = voer_pkg::READ_UNMAPPED;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic sda_s;
   logic [7:0] rd_now;

   always_comb begin
      next_r = r;
      next_r.scl_sync = {r.scl_sync[0], scl_in};
      next_r.sda_sync = {r.sda_sync[0], sda_in};
      next_r.scl_prev = r.scl_sync[1];
      next_r.sda_prev = r.sda_sync[1];
      sda_s      = r.sda_sync[1];
      scl_rise   = r.scl_sync[1] & ~r.scl_prev;
      scl_fall   = ~r.scl_sync[1] & r.scl_prev;
      start_cond = r.scl_sync[1] & r.scl_prev & r.sda_prev & ~sda_s;
      stop_cond  = r.scl_sync[1] & r.scl_prev & ~r.sda_prev & sda_s;
      rd_now     = read_reg(r.sub, r, field_indicator);

      if (start_cond) begin
         next_r.st       = voer_pkg::VOER_ADDR;
         next_r.bitcnt   = 4'h0;
         next_r.pull_low = 1'b0;
      end else if (stop_cond) begin
         next_r.st       = voer_pkg::VOER_IDLE;
         next_r.pull_low = 1'b0;
      end else if (scl_rise && r.st != voer_pkg::VOER_IDLE) begin
         next_r.bitcnt = r.bitcnt + 4'h1;
         if (r.bitcnt < voer_pkg::BITS_DATA) begin
            next_r.shreg = (r.st == voer_pkg::VOER_RDATA) ? r.shreg
                           : {r.shreg[6:0], sda_s};
         end else if (r.st == voer_pkg::VOER_RDATA && sda_s) begin
            // host answered with no-acknowledge: read burst ends
            next_r.st = voer_pkg::VOER_IDLE;
         end
      end else if (scl_fall) begin
         case (r.st)
            voer_pkg::VOER_ADDR,
            voer_pkg::VOER_SUB,
            voer_pkg::VOER_WDATA: begin
               if (r.bitcnt == voer_pkg::BITS_DATA) begin
                  next_r.pull_low = 1'b1;
                  if (r.st == voer_pkg::VOER_ADDR &&
                      r.shreg[7:1] != DEVICE_ADDR) begin
                     next_r.st       = voer_pkg::VOER_IDLE;
                     next_r.pull_low = 1'b0;
                  end else if (r.st == voer_pkg::VOER_SUB) begin
                     next_r.sub = r.shreg;
                  end else if (r.st == voer_pkg::VOER_WDATA) begin
                     case (r.sub)
                        voer_pkg::ADDR_OUT_ENABLE: next_r.out_enable = r.shreg;
                        voer_pkg::ADDR_STRENGTH_A: next_r.strength_a = r.shreg;
                        voer_pkg::ADDR_STRENGTH_B: next_r.strength_b = r.shreg;
                        default: ; // id and status are read only
                     endcase
                     next_r.sub = r.sub + 8'h01;
                  end
               end else if (r.bitcnt == voer_pkg::BITS_ACK) begin
                  next_r.bitcnt   = 4'h0;
                  next_r.pull_low = 1'b0;
                  if (r.st == voer_pkg::VOER_ADDR && r.shreg[0]) begin
                     next_r.st       = voer_pkg::VOER_RDATA;
                     next_r.shreg    = rd_now;
                     next_r.pull_low = ~rd_now[7];
                  end else if (r.st == voer_pkg::VOER_ADDR) begin
                     next_r.st = voer_pkg::VOER_SUB;
                  end else begin
                     next_r.st = voer_pkg::VOER_WDATA;
                  end
               end
            end
            voer_pkg::VOER_RDATA: begin
               if (r.bitcnt < voer_pkg::BITS_DATA) begin
                  next_r.shreg    = {r.shreg[6:0], 1'b0};
                  next_r.pull_low = ~r.shreg[6];
               end else if (r.bitcnt == voer_pkg::BITS_DATA) begin
                  next_r.pull_low = 1'b0;
                  next_r.sub      = r.sub + 8'h01;
               end else begin
                  next_r.bitcnt   = 4'h0;
                  next_r.shreg    = rd_now;
                  next_r.pull_low = ~rd_now[7];
               end
            end
            default: begin
               next_r.pull_low = 1'b0;
            end
         endcase
      end

      // pad strength codes
      next_r.strength.port_a_data_strength =
         r.strength_a[voer_pkg::STR_LO_LSB +: 3];
      next_r.strength.clock_group_strength =
         r.strength_a[voer_pkg::STR_MID_LSB +: 3];
      next_r.strength.pixel_clock_strength =
         r.strength_a[voer_pkg::STR_MID_LSB +: 3] |
         {r.strength_a[voer_pkg::STR_TOP_LSB +: 2], 1'b0};
      next_r.strength.port_b_data_strength =
         r.strength_b[voer_pkg::STR_LO_LSB +: 3];
      next_r.strength.sync_group_strength =
         r.strength_b[voer_pkg::STR_MID_LSB +: 3];

      // output enables
      next_r.enables.port_a_oe      = r.out_enable[voer_pkg::OE_PORT_A];
      next_r.enables.port_b_oe      = r.out_enable[voer_pkg::OE_PORT_B];
      next_r.enables.pixel_clock_oe = r.out_enable[voer_pkg::OE_PIXEL_CLK];
      next_r.enables.sync_group_oe  =
         r.out_enable[voer_pkg::OE_SYNC_GROUP];
      next_r.enables.test_data_out_oe =
         r.out_enable[voer_pkg::OE_HALF_LINE] & tap_test_logic_reset;
      next_r.enables.test_data_out =
         r.out_enable[voer_pkg::OE_HALF_LINE] & tap_test_logic_reset &
         half_rate_line_clock;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk) begin
      if (reset) begin
         r            <= '0;
         r.scl_sync   <= 2'h3;
         r.sda_sync   <= 2'h3;
         r.scl_prev   <= 1'b1;
         r.sda_prev   <= 1'b1;
         r.st         <= voer_pkg::VOER_IDLE;
         r.out_enable <= voer_pkg::RST_OUT_ENABLE;
         r.strength_a <= voer_pkg::RST_STRENGTH_A;
         r.strength_b <= voer_pkg::RST_STRENGTH_B;
      end else begin
         r <= next_r;
      end
   end

   assign sda_out  = 1'b0;
   assign sda_oe   = r.pull_low;
   assign strength = r.strength;
   assign enables  = r.enables;

endmodule // voer_regs

// File: dv/voer_regs_checker.sv
// voer_regs_checker: timing relations at the register block pins
// assumes: bound into voer_regs, one clock, synchronous reset
`timescale 1ns/1ns
module voer_regs_checker (
   input wire logic                     clk,
   input wire logic                     reset,
   input wire logic                     scl_in,
   input wire logic                     sda_oe,
   input wire logic                     half_rate_line_clock,
   input wire logic                     tap_test_logic_reset,
   input wire voer_pkg::voer_strength_s strength,
   input wire voer_pkg::voer_enable_s   enables
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_reset_clears: assert property (disable iff (1'b0)
      reset [*2] |=> strength == '0 && enables == '0) else $error("no clear");
   chk_pix_covers: assert property (
      (strength.pixel_clock_strength & strength.clock_group_strength) ==
      strength.clock_group_strength) else $error("pixel strength lost bits");
   chk_pix_lsb: assert property (
      strength.pixel_clock_strength[0] == strength.clock_group_strength[0])
      else $error("pixel strength bit 0 wrong");
   chk_tdo_gate: assert property (
      !tap_test_logic_reset && !$past(tap_test_logic_reset) |->
      !enables.test_data_out_oe) else $error("test pin driven outside reset");
   chk_tdo_clock: assert property (
      enables.test_data_out |-> enables.test_data_out_oe &&
      (half_rate_line_clock || $past(half_rate_line_clock)))
      else $error("test pin not the line clock");
   chk_str_scl_low: assert property (
      $changed(strength) |-> !scl_in && !$past(scl_in))
      else $error("strength changed outside write");
   chk_oe_scl_low: assert property (
      $changed(enables[5:2]) |-> !scl_in && !$past(scl_in))
      else $error("enables changed outside write");
   chk_sda_scl_low: assert property (
      $changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
endmodule // voer_regs_checker

// File: dv/voer_host.sv
// voer_host: serial host model, drives the clock, pulls data low
// assumes: data wire has a pull-up, resolved by the bench
`timescale 1ns/1ns
module voer_host (
   input  wire logic clk,
   input  wire logic sda,
   output      logic scl = 1'b1,
   output      logic sda_low = 1'b0
);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // clock low 5 cycles, high 3: one bit per 160 ns
   task automatic xbit(input logic b, output logic r);
      tick(1);
      sda_low <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(2);
      r = sda;
      tick(1);
      scl <= 1'b0;
   endtask
   // go high: start or repeated start; go low: stop, clock left high
   task automatic frame(input logic go);
      tick(1);
      sda_low <= ~go;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= go;
      tick(4);
      if (go) scl <= 1'b0;
   endtask
   task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(1'b1, r);
      ack = ~r;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] s, d,
                     output logic ok);
      logic [7:0] z;
      logic a0, a1, a2;
      frame(1'b1);
      xbyte({dev, 1'b0}, z, a0);
      xbyte(s, z, a1);
      xbyte(d, z, a2);
      frame(1'b0);
      ok = a0 & a1 & a2;
   endtask
   // single byte read, closed by a not-acknowledge
   task automatic rd(input logic [6:0] dev, input logic [7:0] s,
                     output logic [7:0] q, output logic ok);
      logic [7:0] z;
      logic a0, a1, a2, n;
      frame(1'b1);
      xbyte({dev, 1'b0}, z, a0);
      xbyte(s, z, a1);
      frame(1'b1);
      xbyte({dev, 1'b1}, z, a2);
      xbyte(8'hff, q, n);
      frame(1'b0);
      ok = a0 & a1 & a2;
   endtask
endmodule // voer_host

// File: dv/voer_regs_tb.sv
// voer_regs_tb: register block driven through the host model
// assumes: package, design, host model and checker compiled first
`timescale 1ns/1ns
module voer_regs_tb;
   localparam logic [6:0]  DEV   = 7'h2d;    // arbitrary
   localparam logic [7:0]  MAKER = 8'h6b;    // arbitrary
   localparam logic [15:0] PART  = 16'h4e21; // arbitrary
   logic                     clk = 1'b0;
   logic                     reset = 1'b1;
   logic                     fld = 1'b0;
   logic                     hrc = 1'b0;
   logic                     tap = 1'b0;
   logic                     scl, sda_low, sda_oe, ok;
   logic                     sda_out;
   // open-drain wire: pulled up unless the host pulls low or the device
   // enables its driver, which must then drive a low level
   wire                      sda = ~sda_low & (~sda_oe | sda_out);
   logic [7:0]               mdl [256];
   logic [7:0]               q, a, d;
   int                       miscompares = 0, checks = 0, i;
   voer_pkg::voer_strength_s strength;
   voer_pkg::voer_enable_s   enables;
   initial forever #10 clk = ~clk;
   voer_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   voer_regs #(.DEVICE_ADDR(DEV), .MAKER_ID(MAKER), .PART_NUMBER(PART))
      uut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
           .sda_out(sda_out), .sda_oe(sda_oe), .field_indicator(fld),
           .half_rate_line_clock(hrc), .tap_test_logic_reset(tap),
           .strength(strength), .enables(enables));
   task automatic conclude();
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want) begin
         miscompares++;
         $display("[FAIL] %0t byte %h exp %h", $time, got, want);
      end
   endtask
   task automatic cmp_out();
      logic [7:0]  x, y, e;
      logic [20:0] want;
      x = mdl[8'hf8];
      y = mdl[8'hf9];
      e = mdl[8'hf2];
      want = {x[2:0], x[5:3], x[5:3] | {x[7:6], 1'b0}, y[2:0], y[5:3],
              e[0], e[1], e[2], e[3], e[4] & tap & hrc, e[4] & tap};
      checks++;
      if ({strength, enables} !== want) begin
         miscompares++;
         $display("[FAIL] %0t pins %h exp %h", $time, {strength, enables},
                  want);
      end
   endtask
   task automatic put(input logic [7:0] s, input logic [7:0] v);
      host.wr(DEV, s, v, ok);
      cmp_byte({7'h0, ok}, 8'h01);
      if (s == 8'hf2 || s == 8'hf8 || s == 8'hf9) mdl[s] = v;
   endtask
   task automatic get(input logic [7:0] s);
      host.rd(DEV, s, q, ok);
      cmp_byte({7'h0, ok}, 8'h01);
   endtask
   initial begin
      i = $urandom(44);
      for (i = 0; i < 256; i++)
         mdl[i] = voer_pkg::READ_UNMAPPED;
      mdl[0] = MAKER;
      mdl[1] = PART[7:0];
      mdl[2] = PART[15:8];
      mdl[8'hf2] = voer_pkg::RST_OUT_ENABLE;
      mdl[8'hf8] = voer_pkg::RST_STRENGTH_A;
      mdl[8'hf9] = voer_pkg::RST_STRENGTH_B;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      cmp_out();
      for (i = 0; i < 4; i++) begin
         put(i[7:0], ~mdl[i]);
         fld <= 1'($urandom);
         get(i[7:0]);
         if (i == 3) cmp_byte({7'h0, q[0]}, {7'h0, fld});
         else cmp_byte(q, mdl[i]);
      end
      for (i = 0; i < 12; i++) begin
         a = (i % 3 == 0) ? 8'hf2 : (i % 3 == 1) ? 8'hf8 : 8'hf9;
         d = (i == 3) ? 8'h1f : 8'($urandom);
         if (a == 8'hf9) d = d & 8'h3f;
         tap <= (i == 3) | 1'($urandom);
         hrc <= 1'($urandom);
         put(a, d);
         cmp_out();
         hrc <= ~hrc;
         repeat (3) @(posedge clk);
         cmp_out();
         get(a);
         cmp_byte(q, mdl[a]);
      end
      get(8'h50);
      cmp_byte(q, voer_pkg::READ_UNMAPPED);
      host.wr(DEV ^ 7'h01, 8'hf2, ~mdl[8'hf2], ok);
      cmp_byte({7'h0, ok}, 8'h00);
      cmp_out();
      conclude();
   end
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      conclude();
   end
endmodule // voer_regs_tb
bind voer_regs voer_regs_checker chk (.clk(clk), .reset(reset),
   .scl_in(scl_in), .sda_oe(sda_oe),
   .half_rate_line_clock(half_rate_line_clock),
   .tap_test_logic_reset(tap_test_logic_reset),
   .strength(strength), .enables(enables));
